// File: rfsmw_line_station.sv
// Remote station model that hands finished characters to the receiver.
`timescale 1ns/1ps
module rfsmw_line_station #(
  parameter int GAP = 3
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sendReq,
  input wire logic [11:0] sendWord,
  output logic busy,
  output logic rxStartSeen,
  output logic rxCharDone,
  output logic [7:0] rxCharData,
  output logic rxParityErr,
  output logic rxFrameErr,
  output logic rxBreak,
  output logic rxAdFlag
);
  logic [11:0] held_r;
  int cnt_r;
  wire startNow = sendReq && cnt_r == 0;
  assign busy = cnt_r != 0;
  // Outside a delivery the lines toggle, so stale data never looks valid.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 0;
      held_r <= 12'h000;
      rxStartSeen <= 1'b0;
      rxCharDone <= 1'b0;
      {rxAdFlag, rxBreak, rxFrameErr, rxParityErr, rxCharData} <= 12'h000;
    end else begin
      rxStartSeen <= startNow;
      rxCharDone <= cnt_r == 1;
      if (startNow)
        held_r <= sendWord;
      cnt_r <= startNow ? GAP : (cnt_r != 0 ? cnt_r - 1 : 0);
      {rxAdFlag, rxBreak, rxFrameErr, rxParityErr, rxCharData} <=
        cnt_r == 1 ? held_r : ~{rxAdFlag, rxBreak, rxFrameErr,
        rxParityErr, rxCharData};
    end
  end
endmodule : rfsmw_line_station

// File: rfsmw_pkg.sv
// Shared constants for the receive queue, status and multidrop wake block.
package rfsmw_pkg;
  localparam int QDEPTH = 256;
  localparam int QAW = 8;
  localparam int WORDW = 11;
  localparam int PAW = 8;
  // Register byte offsets.
  localparam logic [7:0] OFS_MODE0 = 8'h00;
  localparam logic [7:0] OFS_MODE1 = 8'h04;
  localparam logic [7:0] OFS_MODE2 = 8'h08;
  localparam logic [7:0] OFS_MODE3 = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;
  localparam logic [7:0] OFS_DATA = 8'h18;
  localparam logic [7:0] OFS_STATION = 8'h1c;
  localparam logic [7:0] OFS_LEVEL = 8'h20;
  // Queue word layout.
  localparam int W_PAR = 8;
  localparam int W_BRK = 10;
  // Mode register fields.
  localparam int M1_ADTX = 2;
  localparam int M1_PARLO = 3;
  localparam int M1_PARHI = 4;
  localparam int M1_BLOCK = 5;
  localparam logic [1:0] PAR_WAKE = 2'h3;
  localparam int M2_LVLLO = 2;
  localparam int M2_LVLHI = 3;
  localparam int M3_WAKE = 0;
  localparam int M3_DOZE = 1;
  localparam int M3_ALOAD = 6;
  // Status register bit positions.
  localparam int S_AVAIL = 0;
  localparam int S_FULL = 1;
  localparam int S_OVR = 4;
  localparam int S_ERRLO = 5;
  // Bid thresholds.
  localparam logic [QAW:0] LVL_ONE = 9'h001;
  localparam logic [QAW:0] LVL_QTR = 9'h040;
  localparam logic [QAW:0] LVL_3QTR = 9'h0c0;
  localparam logic [QAW:0] LVL_FULL = 9'h100;
  localparam logic [7:0] BID_FULL = 8'hff;
  // Command codes.
  typedef enum logic [3:0] {
    RFSMW_CMD_NOP = 4'h0,
    RFSMW_CMD_RXEN = 4'h1,
    RFSMW_CMD_RXDIS = 4'h2,
    RFSMW_CMD_RXRST = 4'h3,
    RFSMW_CMD_ERRRST = 4'h4,
    RFSMW_CMD_ONENTRY = 4'h5,
    RFSMW_CMD_ONEXIT = 4'h6
  } rfsmw_cmd_t;
endpackage : rfsmw_pkg

// File: rfsmw_queue.sv
// Receive queue storage: word array, pointers and occupancy count.
`timescale 1ns/1ps
module rfsmw_queue #(
  parameter int DEPTH = 256
) (
  input wire logic core_clk,
  input wire logic reset,
  rfsmw_queue_if.store q
);
  localparam int AW = rfsmw_pkg::QAW;

  if (DEPTH != (1 << AW)) begin : g_depthCheck
    $error("Queue depth must match the pointer width.");
  end

  logic [rfsmw_pkg::WORDW-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;

  always_ff @(posedge core_clk) begin
    if (q.push) begin
      mem[wrPtr_r] <= q.pushWord;
    end
  end

  // Flushing moves the read pointer to the write pointer and clears the count; the stored words stay. 
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (q.flush) begin
      rdPtr_r <= wrPtr_r;
      count_r <= '0;
    end else begin
      if (q.push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (q.pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      count_r <= count_r + {{AW{1'b0}}, q.push} - {{AW{1'b0}}, q.pop};
    end
  end

  assign q.headWord = mem[rdPtr_r];
  assign q.count = count_r;
endmodule : rfsmw_queue

// File: rfsmw_queue_if.sv
// Carrier between the receive control logic and the queue storage.
`timescale 1ns/1ps
interface rfsmw_queue_if;
  logic push;
  logic pop;
  logic flush;
  logic [rfsmw_pkg::WORDW-1:0] pushWord;
  logic [rfsmw_pkg::WORDW-1:0] headWord;
  logic [rfsmw_pkg::QAW:0] count;
  modport ctrl (output push, output pop, output flush, output pushWord,
    input headWord, input count);
  modport store (input push, input pop, input flush, input pushWord,
    output headWord, output count);
endinterface : rfsmw_queue_if

// File: rfsmw_rx_top.sv
// Receive queue, status reporting and multidrop wake control of one channel.
`timescale 1ns/1ps
module rfsmw_rx_top #(
  parameter int QDEPTH = rfsmw_pkg::QDEPTH
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rfsmw_pkg::PAW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxCharDone,
  input wire logic [7:0] rxCharData,
  input wire logic rxParityErr,
  input wire logic rxFrameErr,
  input wire logic rxBreak,
  input wire logic rxAdFlag,
  input wire logic rxStartSeen,
  output logic rxHuntEnable,
  output logic rxAbort,
  output logic txAddrFlag,
  output logic [7:0] rxBid,
  output logic rxBidValid,
  output logic characterAvailableFlag,
  output logic receiveQueueFullFlag
);
  localparam int WW = rfsmw_pkg::WORDW;
  localparam int QW = rfsmw_pkg::QAW;

  if (QDEPTH != rfsmw_pkg::QDEPTH) begin : g_depthCheck
    $error("Only the documented queue depth is supported.");
  end

  function automatic logic isAt(input logic [7:0] a, input logic [7:0] o);
    isAt = (a == o);
  endfunction : isAt

  function automatic logic [QW:0] bidLevel(input logic [1:0] sel);
    case (sel)
      2'h0: bidLevel = rfsmw_pkg::LVL_ONE;
      2'h1: bidLevel = rfsmw_pkg::LVL_QTR;
      2'h2: bidLevel = rfsmw_pkg::LVL_3QTR;
      default: bidLevel = rfsmw_pkg::LVL_FULL;
    endcase
  endfunction : bidLevel

  function automatic logic [2:0] wordErr(input logic [WW-1:0] w);
    wordErr = w[rfsmw_pkg::W_BRK:rfsmw_pkg::W_PAR];
  endfunction : wordErr

  function automatic logic [31:0] toWord(input logic [7:0] b);
    toWord = {24'h0, b};
  endfunction : toWord

  rfsmw_queue_if qi ();

  rfsmw_queue #(
    .DEPTH(QDEPTH)
  ) u_queue (
    .core_clk(core_clk),
    .reset(reset),
    .q(qi.store)
  );

  logic [7:0] mode0_r;
  logic [7:0] mode1_r;
  logic [7:0] mode2_r;
  logic [7:0] mode3_r;
  logic [7:0] station_r;
  logic rxEn_r;
  logic onEntry_r;
  logic overrun_r;
  logic [2:0] blockErr_r;
  logic [2:0] blockErr_nxt;
  logic holdValid_r;
  logic [WW-1:0] hold_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic rxHunt_r;
  logic rxAbort_r;
  logic txAddr_r;
  logic [7:0] rxBid_r;
  logic rxBidValid_r;
  logic avail_r;
  logic full_r;

  // Bus decode.
  wire [7:0] addr = paddr;
  wire setup = psel & ~penable;
  wire done = psel & penable & pready_r;
  wire hitM0 = isAt(addr, rfsmw_pkg::OFS_MODE0);
  wire hitM1 = isAt(addr, rfsmw_pkg::OFS_MODE1);
  wire hitM2 = isAt(addr, rfsmw_pkg::OFS_MODE2);
  wire hitM3 = isAt(addr, rfsmw_pkg::OFS_MODE3);
  wire hitSt = isAt(addr, rfsmw_pkg::OFS_STATUS);
  wire hitCmd = isAt(addr, rfsmw_pkg::OFS_CMD);
  wire hitData = isAt(addr, rfsmw_pkg::OFS_DATA);
  wire hitStn = isAt(addr, rfsmw_pkg::OFS_STATION);
  wire hitLvl = isAt(addr, rfsmw_pkg::OFS_LEVEL);
  wire hitAny = hitM0 | hitM1 | hitM2 | hitM3 | hitSt | hitCmd | hitData
    | hitStn | hitLvl;
  wire wrDone = done & pwrite & ~pslverr_r;
  wire rdDone = done & ~pwrite & ~pslverr_r;
  wire [3:0] cmdCode = pwdata[3:0];
  wire cmdWr = wrDone & hitCmd;
  wire cmdEn = cmdWr & (cmdCode == rfsmw_pkg::RFSMW_CMD_RXEN);
  wire cmdDis = cmdWr & (cmdCode == rfsmw_pkg::RFSMW_CMD_RXDIS);
  wire cmdRst = cmdWr & (cmdCode == rfsmw_pkg::RFSMW_CMD_RXRST);
  wire cmdErr = cmdWr & (cmdCode == rfsmw_pkg::RFSMW_CMD_ERRRST);
  wire cmdEntry = cmdWr & (cmdCode == rfsmw_pkg::RFSMW_CMD_ONENTRY);
  wire cmdExit = cmdWr & (cmdCode == rfsmw_pkg::RFSMW_CMD_ONEXIT);

  // Register write strobes.
  wire wrM0 = wrDone & hitM0;
  wire wrM1 = wrDone & hitM1;
  wire wrM2 = wrDone & hitM2;
  wire wrM3 = wrDone & hitM3;
  wire wrStn = wrDone & hitStn;

  // Mode decode.
  wire [1:0] parSel = mode1_r[rfsmw_pkg::M1_PARHI:rfsmw_pkg::M1_PARLO];
  wire wakeMode = (parSel == rfsmw_pkg::PAR_WAKE);
  wire autoWake = mode3_r[rfsmw_pkg::M3_WAKE];
  wire autoDoze = mode3_r[rfsmw_pkg::M3_DOZE];
  wire autoAny = autoWake | autoDoze;
  wire addrLoad = mode3_r[rfsmw_pkg::M3_ALOAD];
  wire blockMode = mode1_r[rfsmw_pkg::M1_BLOCK];
  wire [1:0] lvlSel = mode2_r[rfsmw_pkg::M2_LVLHI:rfsmw_pkg::M2_LVLLO];

  // Incoming character handling.
  wire charIn = rxCharDone & rxHunt_r;
  wire isAddr = wakeMode & rxAdFlag;
  wire match = (rxCharData == station_r);
  wire doWake = charIn & isAddr & autoWake & match;
  wire doDoze = charIn & isAddr & autoDoze & ~match;
  wire keepAddr = autoAny ? addrLoad : 1'b1;
  wire keep = isAddr ? keepAddr : rxEn_r;
  wire accept = charIn & keep & ~cmdRst;
  wire parSlot = wakeMode ? rxAdFlag : rxParityErr;
  // Framing and break go in unchanged in either mode.
  wire [WW-1:0] newWord = {rxBreak, rxFrameErr, parSlot, rxCharData};

  // Queue traffic.
  wire [QW:0] count = qi.count;
  wire qFull = (count == rfsmw_pkg::LVL_FULL);
  wire qEmpty = (count == '0);
  wire holdPush = holdValid_r & ~qFull & ~cmdRst;
  wire newPush = accept & ~qFull & ~holdValid_r;
  wire toHold = accept & (qFull | holdValid_r);
  wire ovrEvent = rxStartSeen & rxHunt_r & qFull & holdValid_r;
  // Only a completed data read pops; status reads leave the queue alone.
  wire doPop = rdDone & hitData & ~qEmpty & ~cmdRst;
  wire [2:0] headErr = wordErr(qi.headWord);
  wire [2:0] pushErr = wordErr(qi.pushWord);
  wire [2:0] entrySet = (onEntry_r & qi.push) ? pushErr : 3'h0;
  wire [2:0] exitSet = (~onEntry_r & doPop) ? headErr : 3'h0;
  wire [2:0] headShow = qEmpty ? 3'h0 : headErr;
  wire [2:0] upperStat = blockMode ? blockErr_r : headShow;

  assign qi.push = holdPush | newPush;
  assign qi.pushWord = holdValid_r ? hold_r : newWord;
  assign qi.pop = doPop;
  assign qi.flush = cmdRst;

  // Read data.
  // Bits 3 and 2 are spare and read as zero.
  logic [7:0] statusByte;
  always_comb begin
    statusByte = 8'h00;
    statusByte[rfsmw_pkg::S_AVAIL] = ~qEmpty;
    statusByte[rfsmw_pkg::S_FULL] = qFull;
    statusByte[rfsmw_pkg::S_OVR] = overrun_r;
    statusByte[rfsmw_pkg::S_ERRLO+:3] = upperStat;
  end
  wire [31:0] rdMux =
    hitM0 ? toWord(mode0_r) :
    hitM1 ? toWord(mode1_r) :
    hitM2 ? toWord(mode2_r) :
    hitM3 ? toWord(mode3_r) :
    hitSt ? toWord(statusByte) :
    hitData ? toWord(qi.headWord[7:0]) :
    hitStn ? toWord(station_r) :
    hitLvl ? {23'h0, count} :
    32'h0;

  // Next values of the registered outputs and the overrun flag.
  wire rxHunt_nxt = wakeMode | (rxEn_r & ~cmdDis & ~cmdRst) | cmdEn;
  wire rxAbort_nxt = (cmdDis | cmdRst) & ~wakeMode;
  wire txAddr_nxt = wakeMode & mode1_r[rfsmw_pkg::M1_ADTX];
  wire [7:0] rxBid_nxt = qFull ? rfsmw_pkg::BID_FULL : count[7:0];
  wire rxBidValid_nxt = ~qEmpty & (count >= bidLevel(lvlSel));
  wire overrun_nxt = (overrun_r & ~cmdErr) | ovrEvent;

  // Block latches: a set in the clearing cycle survives.
  always_comb begin
    blockErr_nxt = cmdRst ? 3'h0 : blockErr_r;
    blockErr_nxt = blockErr_nxt | entrySet | exitSet;
  end

  // Bus slave; every access takes one setup and one access cycle.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~hitAny;
      if (setup & ~pwrite) begin
        prdata_r <= rdMux;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode0_r <= 8'h00;
      mode1_r <= 8'h00;
      mode2_r <= 8'h00;
      mode3_r <= 8'h00;
      station_r <= 8'h00;
    end else begin
      if (wrM0) mode0_r <= pwdata[7:0];
      if (wrM1) mode1_r <= pwdata[7:0];
      if (wrM2) mode2_r <= pwdata[7:0];
      if (wrM3) mode3_r <= pwdata[7:0];
      if (wrStn) station_r <= pwdata[7:0];
    end
  end

  // Receiver enable, with host commands taking priority over auto control.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rxEn_r <= 1'b0;
      onEntry_r <= 1'b0;
    end else begin
      if (cmdDis | cmdRst) begin
        rxEn_r <= 1'b0;
      end else if (cmdEn) begin
        rxEn_r <= 1'b1;
      end else if (doWake) begin
        rxEn_r <= 1'b1;
      end else if (doDoze) begin
        rxEn_r <= 1'b0;
      end
      if (cmdEntry) begin
        onEntry_r <= 1'b1;
      end else if (cmdExit) begin
        onEntry_r <= 1'b0;
      end
    end
  end

  // Holding register for the character after the queue is full.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      holdValid_r <= 1'b0;
      hold_r <= '0;
    end else if (cmdRst) begin
      holdValid_r <= 1'b0;
    end else if (toHold) begin
      holdValid_r <= 1'b1;
      hold_r <= newWord;
    end else if (holdPush | ovrEvent) begin
      holdValid_r <= 1'b0;
    end
  end

  // Overrun: a new overrun in the error reset cycle is kept.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      overrun_r <= 1'b0;
      blockErr_r <= 3'h0;
    end else begin
      overrun_r <= overrun_nxt;
      blockErr_r <= blockErr_nxt;
    end
  end

  // Registered outputs toward the front end, transmitter and arbiter.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rxHunt_r <= 1'b0;
      rxAbort_r <= 1'b0;
      txAddr_r <= 1'b0;
      rxBid_r <= 8'h00;
      rxBidValid_r <= 1'b0;
      avail_r <= 1'b0;
      full_r <= 1'b0;
    end else begin
      rxHunt_r <= rxHunt_nxt;
      rxAbort_r <= rxAbort_nxt;
      txAddr_r <= txAddr_nxt;
      rxBid_r <= rxBid_nxt;
      rxBidValid_r <= rxBidValid_nxt;
      avail_r <= ~qEmpty;
      full_r <= qFull;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign rxHuntEnable = rxHunt_r;
  assign rxAbort = rxAbort_r;
  assign txAddrFlag = txAddr_r;
  assign rxBid = rxBid_r;
  assign rxBidValid = rxBidValid_r;
  assign characterAvailableFlag = avail_r;
  assign receiveQueueFullFlag = full_r;
endmodule : rfsmw_rx_top

// File: rfsmw_rx_top_asserts.sv
// Port-level checks on the receive queue, status and wake block.
`timescale 1ns/1ps
module rfsmw_rx_top_asserts #(
  parameter int QDEPTH = 256
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rfsmw_pkg::PAW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic rxCharDone,
  input wire logic rxHuntEnable,
  input wire logic rxAbort,
  input wire logic txAddrFlag,
  input wire logic [7:0] rxBid,
  input wire logic rxBidValid,
  input wire logic characterAvailableFlag,
  input wire logic receiveQueueFullFlag
);
  logic [7:0] modeOne_r;
  wire acc = psel && penable && pready;
  wire wrCmd = acc && pwrite && paddr == rfsmw_pkg::OFS_CMD;
  wire stopCmd = pwdata[3:0] == rfsmw_pkg::RFSMW_CMD_RXDIS ||
    pwdata[3:0] == rfsmw_pkg::RFSMW_CMD_RXRST;
  wire wake = modeOne_r[4:3] == rfsmw_pkg::PAR_WAKE;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset)
      modeOne_r <= 8'h00;
    else if (acc && pwrite && paddr == rfsmw_pkg::OFS_MODE1)
      modeOne_r <= pwdata[7:0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_full;
    receiveQueueFullFlag |-> rxBid == rfsmw_pkg::BID_FULL && rxBidValid;
  endproperty
  a_full: assert property (p_full) else $error("full bid wrong");
  property p_empty;
    !characterAvailableFlag |-> rxBid == 8'h00 && !rxBidValid;
  endproperty
  a_empty: assert property (p_empty) else $error("empty bids");
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready timing");
  property p_abort;
    wrCmd && stopCmd && !wake |=> ##[0:1] rxAbort;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_noabort;
    wake && $past(wake) |-> !rxAbort && rxHuntEnable;
  endproperty
  a_noabort: assert property (p_noabort) else $error("wake hunt");
  property p_tx;
    txAddrFlag == $past(wake && modeOne_r[rfsmw_pkg::M1_ADTX]);
  endproperty
  a_tx: assert property (p_tx) else $error("tx flag wrong");
  property p_char_in;
    rxCharDone && rxHuntEnable && !wake && !(psel && penable) &&
      !$past(psel && penable) |-> ##2 characterAvailableFlag && rxBid != 0;
  endproperty
  a_char_in: assert property (p_char_in) else $error("char lost");
  property p_one_bid;
    $rose(characterAvailableFlag) |-> rxBid == 8'h01;
  endproperty
  a_one_bid: assert property (p_one_bid) else $error("first bid");
  c_full: cover property (receiveQueueFullFlag);
  c_abort: cover property (rxAbort);
  c_wake: cover property (wake && rxCharDone);
endmodule : rfsmw_rx_top_asserts
bind rfsmw_rx_top rfsmw_rx_top_asserts #(.QDEPTH(QDEPTH)) chk_i (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .rxCharDone(rxCharDone), .rxHuntEnable(rxHuntEnable), .rxAbort(rxAbort),
  .txAddrFlag(txAddrFlag), .rxBid(rxBid), .rxBidValid(rxBidValid),
  .characterAvailableFlag(characterAvailableFlag),
  .receiveQueueFullFlag(receiveQueueFullFlag));

// File: tb.sv
// Bench: host and line traffic against a queue model of the receiver.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic reset = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic sendReq = 1'b0;
  logic wk = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] a;
  logic [11:0] sendWord = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] seed = 32'h41d;
  logic [31:0] v, prdata, rdv;
  logic [7:0] rxCharData, rxBid;
  logic pready, pslverr, errv, busy, rxCharDone, rxParityErr, rxFrameErr;
  logic rxBreak, rxAdFlag, rxStartSeen, rxHuntEnable, rxAbort, txAddrFlag;
  logic rxBidValid, characterAvailableFlag, receiveQueueFullFlag;
  logic [8:0] thr [4];
  logic [10:0] q [$];
  int n_mismatch = 0;
  int total_checks = 0;
  rfsmw_rx_top rfsmw_rx_top_i (.core_clk(core_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxCharDone(rxCharDone), .rxCharData(rxCharData),
    .rxParityErr(rxParityErr), .rxFrameErr(rxFrameErr), .rxBreak(rxBreak),
    .rxAdFlag(rxAdFlag), .rxStartSeen(rxStartSeen),
    .rxHuntEnable(rxHuntEnable), .rxAbort(rxAbort), .txAddrFlag(txAddrFlag),
    .rxBid(rxBid), .rxBidValid(rxBidValid),
    .characterAvailableFlag(characterAvailableFlag),
    .receiveQueueFullFlag(receiveQueueFullFlag));
  rfsmw_line_station rfsmw_line_station_i (.core_clk(core_clk),
    .reset(reset), .sendReq(sendReq), .sendWord(sendWord), .busy(busy),
    .rxStartSeen(rxStartSeen), .rxCharDone(rxCharDone),
    .rxCharData(rxCharData), .rxParityErr(rxParityErr),
    .rxFrameErr(rxFrameErr), .rxBreak(rxBreak), .rxAdFlag(rxAdFlag));
  initial forever #12.5 core_clk = ~core_clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      n_mismatch++;
    if (n >= 16)
      conclude();
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic rd(input logic [7:0] ad);
    apb(1'b0, ad, 32'h0);
  endtask : rd
  task automatic cmd(input rfsmw_pkg::rfsmw_cmd_t c);
    apb(1'b1, rfsmw_pkg::OFS_CMD, 32'(c));
  endtask : cmd
  task automatic lvl(input int e);
    rd(rfsmw_pkg::OFS_LEVEL);
    chk(rdv, 32'(e));
  endtask : lvl
  // Word layout {ad, break, framing, parity, data}; wake keeps ad as parity.
  task automatic send(input logic [7:0] d, input logic [3:0] f,
    input bit keep);
    int n;
    n = 0;
    sendWord <= {f, d};
    sendReq <= 1'b1;
    @(posedge core_clk);
    sendReq <= 1'b0;
    @(posedge core_clk);
    while (busy === 1'b1 && n < 16) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 16)
      n_mismatch++;
    if (n >= 16)
      conclude();
    repeat (3) @(posedge core_clk);
    if (keep)
      q.push_back({f[2:1], wk ? f[3] : f[0], d});
  endtask : send
  task automatic drain();
    logic [10:0] w;
    while (q.size() > 0) begin
      rd(rfsmw_pkg::OFS_STATUS);
      chk(rdv, {24'h0, q[0][10:8], 5'h01});
      w = q.pop_front();
      rd(rfsmw_pkg::OFS_DATA);
      chk(rdv, 32'(w[7:0]));
    end
  endtask : drain
  initial begin
    thr = '{rfsmw_pkg::LVL_ONE, rfsmw_pkg::LVL_QTR, rfsmw_pkg::LVL_3QTR,
      rfsmw_pkg::LVL_FULL};
    reset <= 1'b1;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk(32'({rxBid, characterAvailableFlag, txAddrFlag}), 32'h0);
    for (int i = 0; i < 5; i++) begin
      a = (i == 4) ? rfsmw_pkg::OFS_STATION : 8'(4 * i);
      v = rnd() & 32'hff;
      apb(1'b1, a, v);
      rd(a);
      chk(rdv, v);
      apb(1'b1, a, 32'h0);
    end
    rd(8'h24);
    chk(32'(errv), 32'h1);
    chk(rdv, 32'h0);
    cmd(rfsmw_pkg::RFSMW_CMD_RXEN);
    for (int k = 0; k < 3; k++)
      send(8'(rnd()), 4'(rnd() & 32'h7), 1'b1);
    lvl(3);
    rd(rfsmw_pkg::OFS_STATUS);
    v = rdv;
    rd(rfsmw_pkg::OFS_STATUS);
    chk(rdv, v);
    drain();
    cmd(rfsmw_pkg::RFSMW_CMD_RXDIS);
    send(8'h5c, 4'h0, 1'b0);
    lvl(0);
    cmd(rfsmw_pkg::RFSMW_CMD_RXEN);
    for (int lv = 0; lv < 4; lv++) begin
      apb(1'b1, rfsmw_pkg::OFS_MODE2, 32'(lv << 2));
      for (int c = 1; c <= 256; c++) begin
        send(8'(rnd()), 4'h0, 1'b0);
        chk(32'(rxBidValid), 32'(c >= thr[lv]));
      end
      chk(32'({receiveQueueFullFlag, rxBid}), 32'h1ff);
      if (lv == 3) begin
        send(8'h01, 4'h0, 1'b0);
        send(8'h02, 4'h0, 1'b0);
        rd(rfsmw_pkg::OFS_STATUS);
        chk(32'(rdv[4:0]), 32'h13);
        rd(rfsmw_pkg::OFS_DATA);
        lvl(256);
        cmd(rfsmw_pkg::RFSMW_CMD_ERRRST);
        rd(rfsmw_pkg::OFS_STATUS);
        chk(32'(rdv[4]), 32'h0);
      end
      cmd(rfsmw_pkg::RFSMW_CMD_RXRST);
      lvl(0);
      chk(32'(characterAvailableFlag), 32'h0);
      cmd(rfsmw_pkg::RFSMW_CMD_RXEN);
    end
    apb(1'b1, rfsmw_pkg::OFS_MODE1, 32'h20);
    send(8'h11, 4'h0, 1'b0);
    send(8'h22, 4'h1, 1'b0);
    rd(rfsmw_pkg::OFS_DATA);
    rd(rfsmw_pkg::OFS_DATA);
    rd(rfsmw_pkg::OFS_STATUS);
    chk(32'(rdv[7:5]), 32'h1);
    cmd(rfsmw_pkg::RFSMW_CMD_ONENTRY);
    cmd(rfsmw_pkg::RFSMW_CMD_RXRST);
    rd(rfsmw_pkg::OFS_STATUS);
    chk(32'(rdv[7:5]), 32'h0);
    cmd(rfsmw_pkg::RFSMW_CMD_RXEN);
    send(8'h33, 4'h2, 1'b0);
    rd(rfsmw_pkg::OFS_STATUS);
    chk(32'(rdv[7:5]), 32'h2);
    cmd(rfsmw_pkg::RFSMW_CMD_ONEXIT);
    send(8'h66, 4'h4, 1'b0);
    rd(rfsmw_pkg::OFS_STATUS);
    chk(32'(rdv[7:5]), 32'h2);
    rd(rfsmw_pkg::OFS_DATA);
    rd(rfsmw_pkg::OFS_DATA);
    rd(rfsmw_pkg::OFS_STATUS);
    chk(32'(rdv[7:5]), 32'h6);
    cmd(rfsmw_pkg::RFSMW_CMD_RXRST);
    apb(1'b1, rfsmw_pkg::OFS_MODE1, 32'h1c);
    wk = 1'b1;
    repeat (2) @(posedge core_clk);
    chk(32'(txAddrFlag), 32'h1);
    send(8'h44, 4'h0, 1'b0);
    send(8'h55, 4'h8, 1'b1);
    apb(1'b1, rfsmw_pkg::OFS_STATION, 32'h5a);
    apb(1'b1, rfsmw_pkg::OFS_MODE3, 32'h41);
    send(8'h5a, 4'h8, 1'b1);
    send(8'(rnd()), 4'h0, 1'b1);
    apb(1'b1, rfsmw_pkg::OFS_MODE3, 32'h02);
    send(8'h33, 4'h8, 1'b0);
    send(8'(rnd()), 4'h0, 1'b0);
    lvl(3);
    drain();
    apb(1'b1, rfsmw_pkg::OFS_MODE3, 32'h43);
    send(8'h5a, 4'h8, 1'b1);
    send(8'h6e, 4'h2, 1'b1);
    send(8'h77, 4'h8, 1'b1);
    send(8'(rnd()), 4'h0, 1'b0);
    lvl(3);
    drain();
    conclude();
  end
endmodule : tb
